// >>> inc/lcc_pkg.sv
// Shared constants, types and helpers for the logic cluster
// Assumes a single clk_sys domain; included by every cluster file
package lcc_pkg;

	// ------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------
	localparam int NUM_CELLS = 10;
	localparam int LUT_IN = 4;
	localparam int LUT_BITS = 16;
	localparam int ROW_CLKS = 8;
	localparam int CTRL_LINES = 8;
	localparam int CTRL_SRCS = 16;
	localparam int CTRL_SEL_W = 4;
	localparam int NUM_CTRL = 10;
	localparam int REACH = 30;
	localparam int ROUTE_INS = 8;
	localparam int POOL = 38;
	localparam int POOL_SEL_W = 6;
	localparam int CELL_OUTS = 3;
	localparam int CNT_W = 4;

	// ------------------------------------------------------------
	// Control slot positions
	// ------------------------------------------------------------
	localparam int CTL_CLK1 = 0;
	localparam int CTL_CLK2 = 1;
	localparam int CTL_ENA1 = 2;
	localparam int CTL_ENA2 = 3;
	localparam int CTL_ACLR1 = 4;
	localparam int CTL_ACLR2 = 5;
	localparam int CTL_SCLR = 6;
	localparam int CTL_ALOAD = 7;
	localparam int CTL_SLOAD = 8;
	localparam int CTL_ADDNSUB = 9;

	// ------------------------------------------------------------
	// Values after reset and idle levels
	// ------------------------------------------------------------
	localparam logic REG_RST_VAL = 1'h0;
	localparam logic ADDNSUB_IDLE = 1'h1;
	localparam logic ENA_IDLE = 1'h1;

	typedef enum logic [1:0] {
		REG_D = 2'h0,
		REG_T = 2'h1,
		REG_JK = 2'h3,
		REG_SR = 2'h2
	} lcc_reg_mode_t;

	typedef enum logic [1:0] {
		DSRC_LUT = 2'h0,
		DSRC_CHAIN = 2'h1,
		DSRC_DATA = 2'h3
	} lcc_dsrc_t;

	function automatic logic lcc_pool_pick(input logic [POOL-1:0] pool,
		input logic [POOL_SEL_W-1:0] sel);
		if (int'(sel) < POOL) begin
			return pool[sel];
		end
		return 1'h0;
	endfunction

	function automatic logic [CNT_W-1:0] lcc_count(
		input logic [NUM_CTRL-1:0] v);
		logic [CNT_W-1:0] n;
		n = '0;
		for (int i = 0; i < NUM_CTRL; i++) begin
			n = n + CNT_W'(v[i]);
		end
		return n;
	endfunction

endpackage

// >>> core/lcc_ctrl.sv
// Cluster-wide control generation: clock ticks, clears, loads, add/sub
// Assumes row clocks and control lines are levels sampled on clk_sys
`timescale 1ns/100ps

module lcc_ctrl (
	input wire logic clk_sys, // System clock
	input wire logic rst, // Synchronous reset
	input wire logic [lcc_pkg::ROW_CLKS-1:0] row_clk, // Row clock lines
	input wire logic [lcc_pkg::CTRL_LINES-1:0] ctrl_line, // Local lines
	input wire logic [lcc_pkg::NUM_CTRL-1:0][lcc_pkg::CTRL_SEL_W-1:0]
		ctrl_sel, // Source per slot
	input wire logic [lcc_pkg::NUM_CTRL-1:0] ctrl_use, // Slot in use
	input wire logic [1:0] clk_fall, // Clock slot uses falling edge
	output logic [1:0] tick, // Gated clock events
	output logic [1:0] aclr, // Async clears
	output logic sclr, // Sync clear
	output logic aload, // Async load/preset
	output logic sload, // Sync load
	output logic add_nsub // High add, low subtract
);
	import lcc_pkg::*;

	logic [CTRL_SRCS-1:0] src;
	logic [CTRL_SRCS-1:0] src_q;
	logic [CTRL_SRCS-1:0] rise;
	logic [CTRL_SRCS-1:0] fall;
	logic [NUM_CTRL-1:0] lvl;

	// ------------------------------------------------------------
	// Source selection
	// ------------------------------------------------------------
	assign src = {ctrl_line, row_clk};
	assign rise = src & ~src_q;
	assign fall = ~src & src_q;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			src_q <= '0;
		end else begin
			src_q <= src;
		end
	end

	always_comb begin
		for (int i = 0; i < NUM_CTRL; i++) begin
			lvl[i] = ctrl_use[i] & src[ctrl_sel[i]];
		end
	end

	// ------------------------------------------------------------
	// Clock events, each paired with its own enable
	// ------------------------------------------------------------
	always_comb begin
		for (int k = 0; k < 2; k++) begin
			tick[k] = ctrl_use[CTL_CLK1 + k] &
				(clk_fall[k] ? fall[ctrl_sel[CTL_CLK1 + k]]
				: rise[ctrl_sel[CTL_CLK1 + k]]) &
				(ctrl_use[CTL_ENA1 + k] ? src[ctrl_sel[CTL_ENA1 + k]]
				: ENA_IDLE);
		end
	end

	assign aclr = lvl[CTL_ACLR2:CTL_ACLR1];
	assign sclr = lvl[CTL_SCLR];
	assign aload = lvl[CTL_ALOAD];
	assign sload = lvl[CTL_SLOAD];
	assign add_nsub = ctrl_use[CTL_ADDNSUB] ? src[ctrl_sel[CTL_ADDNSUB]]
		: ADDNSUB_IDLE;

endmodule

// >>> core/lcc_cell.sv
// One logic cell: four-input lookup, one-bit add/sub, programmable register
// Assumes control levels come from lcc_ctrl in the same clock domain
`timescale 1ns/100ps

module lcc_cell (
	input wire logic clk_sys, // System clock
	input wire logic rst, // Synchronous reset
	input wire logic chip_wide_reset_n, // Chip reset, low active
	input wire logic [lcc_pkg::LUT_BITS-1:0] lut_mask, // Truth table
	input wire lcc_pkg::lcc_reg_mode_t reg_mode, // Register kind
	input wire lcc_pkg::lcc_dsrc_t dsrc, // Register data source
	input wire logic arith_en, // Add/sub instead of lookup
	input wire logic [lcc_pkg::LUT_IN-1:0] lut_in, // Cell inputs
	input wire logic chain_in, // Previous cell register
	input wire logic b_inv, // Invert B operand
	input wire logic cin, // Carry in
	input wire logic tick, // Clock event
	input wire logic aclr, // Async clear
	input wire logic aload, // Async load
	input wire logic sclr, // Sync clear
	input wire logic sload, // Sync load
	output logic lut_out, // Lookup or sum result
	output logic reg_q, // Register state
	output logic cout // Carry out
);
	import lcc_pkg::*;

	logic a;
	logic b;
	logic d;
	logic q_d;

	// ------------------------------------------------------------
	// Lookup and arithmetic
	// ------------------------------------------------------------
	assign a = lut_in[0];
	assign b = lut_in[1] ^ b_inv;
	assign cout = (a & b) | (cin & (a ^ b));
	assign lut_out = arith_en ? (a ^ b ^ cin) : lut_mask[lut_in];

	// ------------------------------------------------------------
	// Register
	// ------------------------------------------------------------
	always_comb begin
		case (dsrc)
			DSRC_CHAIN: d = chain_in;
			DSRC_DATA: d = lut_in[2];
			default: d = lut_out;
		endcase
	end

	always_comb begin
		q_d = reg_q;
		if (sclr) begin
			q_d = REG_RST_VAL;
		end else if (sload) begin
			q_d = lut_in[2];
		end else begin
			case (reg_mode)
				REG_T: q_d = reg_q ^ d;
				REG_JK: q_d = (d & ~reg_q) | (~lut_in[1] & reg_q);
				REG_SR: q_d = (d & ~lut_in[1]) | (~(d ^ lut_in[1]) & reg_q);
				default: q_d = d;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst || !chip_wide_reset_n) begin
			reg_q <= REG_RST_VAL;
		end else if (aclr) begin
			reg_q <= REG_RST_VAL;
		end else if (aload) begin
			reg_q <= lut_in[3];
		end else if (tick) begin
			reg_q <= q_d;
		end
	end

endmodule

// >>> core/lcc_cluster.sv
// Logic cluster: ten cells with shared control, chains and local routing
// Assumes static configuration and inputs synchronous to clk_sys
// Function
// - The cluster holds exactly ten logic cells sharing control and chains.
// - Each cell's lookup output can feed the next cell's lookup.
// - Each cell's register output can feed the next cell's register.
// - The register chain shifts independently of the lookup functions.
// - Each cell input can reach thirty cells over local and side links.
// - At most ten control signals serve the cluster at once.
// - Each cluster clock is gated only by its own paired enable.
// - Using both edges of one clock takes both cluster clocks.
// - Dropping a clock enable stops that clock for every cell on it.
// - Async load with its data input high presets the register.
// - Controls come from the eight row clocks and local lines.
// - Each cell has a four-input lookup for any Boolean function.
// - Each register works as D, T, JK or SR flip-flop.
// - Register has data, load data, clock, enable, clear, load inputs.
// - Combinational cells bypass the register to their outputs.
// - Three outputs per cell, each picking lookup or register.
// - Packing lets the register feed its own cell's lookup.
// - A cell can show registered and unregistered results together.
// - The add/subtract select picks A plus B or A minus B.
// - Subtract inverts every B bit and forces the low carry-in to one.
// - Async clear wins over async load when both are asserted.
// - The chip-wide reset clears every register above all else.

`timescale 1ns/100ps

module lcc_cluster (
	input wire logic clk_sys, // System clock
	input wire logic rst, // Synchronous reset
	input wire logic chip_wide_reset_n, // Chip reset, low active
	input wire logic [lcc_pkg::ROW_CLKS-1:0] row_clk, // Row clocks
	input wire logic [lcc_pkg::CTRL_LINES-1:0] ctrl_line, // Local lines
	input wire logic [lcc_pkg::NUM_CTRL-1:0][lcc_pkg::CTRL_SEL_W-1:0]
		ctrl_sel, // Control sources
	input wire logic [lcc_pkg::NUM_CTRL-1:0] ctrl_use, // Controls used
	input wire logic [1:0] clk_fall, // Falling edge per clock
	input wire logic [lcc_pkg::NUM_CELLS-1:0] dl_left_in, // Left links
	input wire logic [lcc_pkg::NUM_CELLS-1:0] dl_right_in, // Right links
	input wire logic [lcc_pkg::ROUTE_INS-1:0] route_in, // Row/column
	input wire logic reg_chain_in, // Shift chain entry
	input wire logic carry_in, // Cluster carry in
	input wire logic [lcc_pkg::NUM_CELLS-1:0][lcc_pkg::LUT_BITS-1:0]
		lut_mask, // Truth tables
	input wire lcc_pkg::lcc_reg_mode_t [lcc_pkg::NUM_CELLS-1:0]
		reg_mode, // Register kinds
	input wire lcc_pkg::lcc_dsrc_t [lcc_pkg::NUM_CELLS-1:0]
		dsrc, // Register data sources
	input wire logic [lcc_pkg::NUM_CELLS-1:0] clk_pick, // Clock two
	input wire logic [lcc_pkg::NUM_CELLS-1:0][lcc_pkg::LUT_IN-1:0]
		[lcc_pkg::POOL_SEL_W-1:0] in_sel, // Input routing
	input wire logic [lcc_pkg::NUM_CELLS-1:0] lut_chain_en, // Chain in
	input wire logic [lcc_pkg::NUM_CELLS-1:0] pack_fb_en, // Feedback
	input wire logic [lcc_pkg::NUM_CELLS-1:0] arith_en, // Add/sub
	input wire logic [lcc_pkg::NUM_CELLS-1:0][lcc_pkg::CELL_OUTS-1:0]
		out_sel, // Register per output
	output logic [lcc_pkg::NUM_CELLS-1:0] route_out_a, // Routing out A
	output logic [lcc_pkg::NUM_CELLS-1:0] route_out_b, // Routing out B
	output logic [lcc_pkg::NUM_CELLS-1:0] local_out, // Local out
	output logic [lcc_pkg::NUM_CELLS-1:0] cell_reg_q, // Register states
	output logic lut_chain_out, // Last lookup
	output logic reg_chain_out, // Last register
	output logic carry_out, // Cluster carry out
	output logic both_edge_clk, // Both clocks on one source, opposite edges
	output logic [lcc_pkg::CNT_W-1:0] ctrl_in_use // Controls in use
);
	import lcc_pkg::*;

	logic [1:0] tick;
	logic [1:0] aclr;
	logic sclr;
	logic aload;
	logic sload;
	logic add_nsub;
	logic [POOL-1:0] pool;
	logic [NUM_CELLS-1:0] lut_out;
	logic [NUM_CELLS-1:0] reg_q;
	logic [NUM_CELLS-1:0] cout;
	logic [NUM_CELLS-1:0] cin;
	logic [NUM_CELLS-1:0] chain_in;
	logic [NUM_CELLS-1:0] lut_prev;
	logic [NUM_CELLS-1:0][LUT_IN-1:0] cell_in;

	// ------------------------------------------------------------
	// Shared control
	// ------------------------------------------------------------
	lcc_ctrl u_ctrl (
		.clk_sys(clk_sys),
		.rst(rst),
		.row_clk(row_clk),
		.ctrl_line(ctrl_line),
		.ctrl_sel(ctrl_sel),
		.ctrl_use(ctrl_use),
		.clk_fall(clk_fall),
		.tick(tick),
		.aclr(aclr),
		.sclr(sclr),
		.aload(aload),
		.sload(sload),
		.add_nsub(add_nsub)
	);

	assign ctrl_in_use = lcc_count(ctrl_use);

	always_comb begin
		both_edge_clk = ctrl_use[CTL_CLK1] & ctrl_use[CTL_CLK2] &
			(ctrl_sel[CTL_CLK1] == ctrl_sel[CTL_CLK2]) &
			(clk_fall[0] != clk_fall[1]);
	end

	// ------------------------------------------------------------
	// Local routing pool
	// ------------------------------------------------------------
	// Own cells, both side links and row/column lines
	assign pool = {route_in, dl_right_in, dl_left_in, local_out};

	// ------------------------------------------------------------
	// Chains between neighbours
	// ------------------------------------------------------------
	always_comb begin
		lut_prev[0] = 1'h0;
		chain_in[0] = reg_chain_in;
		cin[0] = carry_in | ~add_nsub;
		for (int i = 1; i < NUM_CELLS; i++) begin
			lut_prev[i] = lut_out[i - 1];
			chain_in[i] = reg_q[i - 1];
			cin[i] = cout[i - 1];
		end
	end

	assign lut_chain_out = lut_out[NUM_CELLS - 1];
	assign reg_chain_out = reg_q[NUM_CELLS - 1];
	assign carry_out = cout[NUM_CELLS - 1];

	// ------------------------------------------------------------
	// Cell input selection
	// ------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < NUM_CELLS; i++) begin
			for (int j = 0; j < LUT_IN; j++) begin
				cell_in[i][j] = lcc_pool_pick(pool, in_sel[i][j]);
			end
			if (lut_chain_en[i]) begin
				cell_in[i][0] = lut_prev[i];
			end
			if (pack_fb_en[i]) begin
				cell_in[i][2] = reg_q[i];
			end
		end
	end

	// ------------------------------------------------------------
	// Cells
	// ------------------------------------------------------------
	for (genvar i = 0; i < NUM_CELLS; i++) begin : g_cell
		lcc_cell u_cell (
			.clk_sys(clk_sys),
			.rst(rst),
			.chip_wide_reset_n(chip_wide_reset_n),
			.lut_mask(lut_mask[i]),
			.reg_mode(reg_mode[i]),
			.dsrc(dsrc[i]),
			.arith_en(arith_en[i]),
			.lut_in(cell_in[i]),
			.chain_in(chain_in[i]),
			.b_inv(~add_nsub),
			.cin(cin[i]),
			.tick(clk_pick[i] ? tick[1] : tick[0]),
			.aclr(aclr[0] | aclr[1]),
			.aload(aload),
			.sclr(sclr),
			.sload(sload),
			.lut_out(lut_out[i]),
			.reg_q(reg_q[i]),
			.cout(cout[i])
		);
	end

	// ------------------------------------------------------------
	// Cell outputs
	// ------------------------------------------------------------
	// Lookup paths are combinational so bypassed cells see no latency
	always_comb begin
		for (int i = 0; i < NUM_CELLS; i++) begin
			route_out_a[i] = out_sel[i][0] ? reg_q[i] : lut_out[i];
			route_out_b[i] = out_sel[i][1] ? reg_q[i] : lut_out[i];
			local_out[i] = out_sel[i][2] ? reg_q[i] : lut_out[i];
		end
	end

	assign cell_reg_q = reg_q;

endmodule

// >>> verification/lcc_nbr_model.sv
// Neighbour and routing model for the cluster's side inputs
// Assumes the bench sets the wanted levels; they show one cycle later
`timescale 1ns/100ps
module lcc_nbr_model (
	input wire logic clk_sys, // Clock
	input wire logic [27:0] want, // Levels {route, right, left}
	output logic [9:0] dl_left_in, // Left links
	output logic [9:0] dl_right_in, // Right links
	output logic [7:0] route_in // Row/column lines
);
	always_ff @(posedge clk_sys) begin
		{route_in, dl_right_in, dl_left_in} <= want;
	end
endmodule

// >>> verification/lcc_cluster_assertions.sv
// Port-level assertions for lcc_cluster
// Assumes one clk_sys domain; bound below to every cluster
`timescale 1ns/100ps
module lcc_cluster_chk (
	input wire logic clk_sys, // Clock
	input wire logic rst, // Reset
	input wire logic chip_wide_reset_n, // Chip reset
	input wire logic [lcc_pkg::ROW_CLKS-1:0] row_clk, // Row clocks
	input wire logic [lcc_pkg::CTRL_LINES-1:0] ctrl_line, // Lines
	input wire logic [lcc_pkg::NUM_CTRL-1:0][lcc_pkg::CTRL_SEL_W-1:0]
		ctrl_sel, // Sources
	input wire logic [lcc_pkg::NUM_CTRL-1:0] ctrl_use, // Used
	input wire logic [1:0] clk_fall, // Edges
	input wire logic [lcc_pkg::NUM_CELLS-1:0] clk_pick, // Clock two
	input wire lcc_pkg::lcc_reg_mode_t [lcc_pkg::NUM_CELLS-1:0]
		reg_mode, // Kinds
	input wire lcc_pkg::lcc_dsrc_t [lcc_pkg::NUM_CELLS-1:0]
		dsrc, // Data sources
	input wire logic reg_chain_in, // Chain entry
	input wire logic [lcc_pkg::NUM_CELLS-1:0][lcc_pkg::CELL_OUTS-1:0]
		out_sel, // Picks
	input wire logic [lcc_pkg::NUM_CELLS-1:0] route_out_a, // Out A
	input wire logic [lcc_pkg::NUM_CELLS-1:0] local_out, // Local
	input wire logic [lcc_pkg::NUM_CELLS-1:0] cell_reg_q, // States
	input wire logic lut_chain_out, // Last lookup
	input wire logic reg_chain_out, // Last register
	input wire logic both_edge_clk, // Both edges
	input wire logic [lcc_pkg::CNT_W-1:0] ctrl_in_use // Count
);
	import lcc_pkg::*;
	logic [15:0] src;
	assign src = {ctrl_line, row_clk};
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	a_ctrl_count: assert property (
		ctrl_in_use == CNT_W'($countones(ctrl_use)))
		else $error("bad control count");
	a_chip_reset: assert property (
		!chip_wide_reset_n |=> cell_reg_q == '0)
		else $error("chip reset missed");
	a_clear_wins: assert property (
		ctrl_use[CTL_ACLR1] && src[ctrl_sel[CTL_ACLR1]] &&
		ctrl_use[CTL_ALOAD] && src[ctrl_sel[CTL_ALOAD]] |=> cell_reg_q == '0)
		else $error("clear lost to load");
	a_reg_chain: assert property (
		ctrl_use == 10'h001 && clk_pick == '0 && !clk_fall[0] &&
		dsrc == {NUM_CELLS{DSRC_CHAIN}} &&
		reg_mode == {NUM_CELLS{REG_D}} &&
		chip_wide_reset_n && !$past(rst) && src[ctrl_sel[CTL_CLK1]] &&
		!$past(src[ctrl_sel[CTL_CLK1]]) |=> cell_reg_q ==
		{$past(cell_reg_q[NUM_CELLS-2:0]), $past(reg_chain_in)})
		else $error("chain did not shift");
	a_both_edges: assert property (
		both_edge_clk == (ctrl_use[CTL_CLK1] && ctrl_use[CTL_CLK2] &&
		ctrl_sel[CTL_CLK1] == ctrl_sel[CTL_CLK2] && clk_fall[0] != clk_fall[1]))
		else $error("bad both edge flag");
	a_ena_stops: assert property (
		ctrl_use[CTL_ENA1] && !src[ctrl_sel[CTL_ENA1]] && clk_pick == '0 &&
		ctrl_use[CTL_ACLR2:CTL_ACLR1] == '0 && !ctrl_use[CTL_ALOAD] &&
		chip_wide_reset_n |=> $stable(cell_reg_q))
		else $error("register moved, enable low");
	a_local_reg: assert property (
		out_sel[0][2] |-> local_out[0] == cell_reg_q[0])
		else $error("local out not register");
	a_lut_bypass: assert property (
		!out_sel[NUM_CELLS-1][0] |-> route_out_a[NUM_CELLS-1] == lut_chain_out)
		else $error("out A not lookup");
endmodule
bind lcc_cluster lcc_cluster_chk lcc_cluster_chk_i (.clk_sys, .rst,
	.chip_wide_reset_n, .row_clk, .ctrl_line, .ctrl_sel, .ctrl_use,
	.clk_fall, .clk_pick, .reg_mode, .dsrc, .reg_chain_in,
	.out_sel, .route_out_a, .local_out, .cell_reg_q,
	.lut_chain_out, .reg_chain_out, .both_edge_clk, .ctrl_in_use);

// >>> verification/lcc_cluster_tb_top.sv
// Bench for lcc_cluster: shift, enable, load/clear, add/sub and mode tests
// Assumes the checker bind and lcc_nbr_model are compiled first
`timescale 1ns/100ps
module lcc_cluster_tb_top;
	import lcc_pkg::*;
	logic clk_sys, rst, chip_wide_reset_n, reg_chain_in, carry_in;
	logic lut_chain_out, reg_chain_out, carry_out, both_edge_clk;
	logic [7:0] row_clk, ctrl_line, route_in;
	logic [NUM_CTRL-1:0][CTRL_SEL_W-1:0] ctrl_sel;
	logic [9:0] ctrl_use, dl_left_in, dl_right_in, clk_pick, lut_chain_en;
	logic [9:0] pack_fb_en, arith_en, route_out_a, route_out_b;
	logic [9:0] local_out, cell_reg_q, a, b;
	logic [9:0] pat = 10'h1b5;
	logic [1:0] clk_fall;
	logic [3:0] ctrl_in_use;
	logic [9:0][15:0] lut_mask;
	lcc_reg_mode_t [9:0] reg_mode;
	lcc_dsrc_t [9:0] dsrc;
	logic [9:0][3:0][5:0] in_sel;
	logic [9:0][2:0] out_sel;
	logic [27:0] want;
	logic [10:0] sum;
	logic [21:0] tv [5];
	int num_errors = 0;
	int num_checks = 0;
	lcc_cluster lcc_cluster_i (.clk_sys, .rst, .chip_wide_reset_n, .row_clk,
		.ctrl_line, .ctrl_sel, .ctrl_use, .clk_fall, .dl_left_in, .dl_right_in,
		.route_in, .reg_chain_in, .carry_in, .lut_mask, .reg_mode, .dsrc,
		.clk_pick, .in_sel, .lut_chain_en, .pack_fb_en, .arith_en, .out_sel,
		.route_out_a, .route_out_b, .local_out, .cell_reg_q, .lut_chain_out,
		.reg_chain_out, .carry_out, .both_edge_clk, .ctrl_in_use);
	lcc_nbr_model lcc_nbr_model_i (.clk_sys, .want, .dl_left_in,
		.dl_right_in, .route_in);
	task automatic chk(input logic [10:0] got, input logic [10:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One rising edge on a row clock, chain data set with it
	task automatic pulse(input int k, input logic d);
		@(posedge clk_sys);
		row_clk[k] <= 1'h1;
		reg_chain_in <= d;
		@(posedge clk_sys);
		row_clk[k] <= 1'h0;
		@(negedge clk_sys);
	endtask
	task automatic settle();
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask
	task automatic set_cells(input lcc_reg_mode_t m, input lcc_dsrc_t s);
		for (int i = 0; i < 10; i++) begin
			reg_mode[i] <= m;
			dsrc[i] <= s;
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		clk_sys = 1'h0;
		forever #2 clk_sys = ~clk_sys;
	end
	initial begin
		#20000;
		num_errors++;
		$display("MISMATCH %0t watchdog", $time);
		finish_test();
	end
	initial begin
		rst = 1'h1;
		chip_wide_reset_n = 1'h1;
		{row_clk, ctrl_line, reg_chain_in, carry_in, want} = '0;
		{ctrl_sel, clk_fall, clk_pick, pack_fb_en, arith_en} = '0;
		ctrl_use = 10'h001;
		lut_chain_en = 10'h3ff;
		out_sel = {10{3'h4}};
		lut_mask = {{9{16'haaaa}}, 16'hff00};
		tv = '{{2'h2, 10'h0ab, 10'h155}, {2'h3, 10'h3ff, 10'h001},
			{2'h0, 10'h101, 10'h100}, {2'h0, 10'h0ab, 10'h0ab},
			{2'h1, 10'h003, 10'h005}};
		for (int i = 0; i < 10; i++) begin
			reg_mode[i] = REG_D;
			dsrc[i] = DSRC_CHAIN;
			in_sel[i] = {6'h1e, {3{6'h26}}};
		end
		repeat (2) @(posedge clk_sys);
		rst <= 1'h0;
		for (int j = 9; j >= 0; j--) begin
			pulse(0, pat[j]);
		end
		chk(11'(cell_reg_q), 11'h1b5);
		@(posedge clk_sys);
		want <= 28'h0100000;
		settle();
		chk(11'(lut_chain_out), 11'h1);
		chk(11'(route_out_a[9]), 11'h1);
		chk(11'(local_out[9]), 11'h0);
		chk(11'(cell_reg_q), 11'h1b5);
		$display("shift test done");
		@(posedge clk_sys);
		ctrl_use <= 10'h007;
		ctrl_sel[1] <= 4'h1;
		ctrl_sel[2] <= 4'h8;
		pulse(0, 1'h0);
		chk(11'(cell_reg_q), 11'h1b5);
		chk(11'(ctrl_in_use), 11'h3);
		@(posedge clk_sys);
		clk_pick <= 10'h3ff;
		pulse(1, 1'h1);
		chk(11'(cell_reg_q), 11'h36b);
		@(posedge clk_sys);
		ctrl_sel[1] <= 4'h0;
		clk_fall <= 2'h2;
		pulse(0, 1'h1);
		settle();
		chk(11'(cell_reg_q), 11'h2d7);
		chk(11'(both_edge_clk), 11'h1);
		chk(11'(reg_chain_out), 11'h1);
		$display("enable test done");
		@(posedge clk_sys);
		ctrl_use <= 10'h091;
		{clk_pick, clk_fall} <= '0;
		ctrl_sel[4] <= 4'ha;
		ctrl_sel[7] <= 4'h9;
		ctrl_line[1] <= 1'h1;
		settle();
		chk(11'(cell_reg_q), 11'h3ff);
		@(posedge clk_sys);
		ctrl_line[2] <= 1'h1;
		settle();
		chk(11'(cell_reg_q), 11'h0);
		@(posedge clk_sys);
		ctrl_line[2] <= 1'h0;
		settle();
		chk(11'(cell_reg_q), 11'h3ff);
		@(posedge clk_sys);
		want <= '0;
		settle();
		chk(11'(cell_reg_q), 11'h0);
		@(posedge clk_sys);
		want <= 28'h0100000;
		chip_wide_reset_n <= 1'h0;
		settle();
		chk(11'(cell_reg_q), 11'h0);
		$display("load test done");
		@(posedge clk_sys);
		chip_wide_reset_n <= 1'h1;
		ctrl_line <= '0;
		ctrl_use <= 10'h201;
		ctrl_sel[9] <= 4'hb;
		arith_en <= 10'h3ff;
		lut_chain_en <= '0;
		for (int i = 0; i < 10; i++) begin
			in_sel[i] <= {6'h1e, 6'h26, 6'(20 + i), 6'(10 + i)};
			dsrc[i] <= DSRC_LUT;
		end
		for (int t = 0; t < 5; t++) begin
			@(posedge clk_sys);
			{ctrl_line[3], carry_in} <= tv[t][21:20];
			want <= {8'h0, tv[t][19:0]};
			settle();
			a = tv[t][9:0];
			b = tv[t][19:10];
			if (tv[t][21]) begin
				sum = {1'h0, a} + {1'h0, b} + 11'(tv[t][20]);
			end else begin
				sum = {1'h0, a} + {1'h0, ~b} + 11'h1;
			end
			chk(11'(route_out_a), {1'h0, sum[9:0]});
			chk(11'(carry_out), 11'(sum[10]));
		end
		pulse(0, 1'h0);
		chk(11'(cell_reg_q), {1'h0, sum[9:0]});
		chk(11'(local_out), {1'h0, sum[9:0]});
		chk(11'(route_out_a), {1'h0, sum[9:0]});
		chk(11'(route_out_b), {1'h0, sum[9:0]});
		$display("arith test done");
		@(posedge clk_sys);
		ctrl_use <= 10'h141;
		ctrl_sel[6] <= 4'hc;
		ctrl_sel[8] <= 4'hd;
		ctrl_line[4] <= 1'h1;
		arith_en <= '0;
		want <= 28'h00000f5;
		set_cells(REG_T, DSRC_DATA);
		for (int i = 0; i < 10; i++) begin
			in_sel[i] <= {6'h26, 6'(10 + i), 6'(20 + i), 6'h26};
		end
		pulse(0, 1'h0);
		chk(11'(cell_reg_q), 11'h0);
		@(posedge clk_sys);
		ctrl_line[4] <= 1'h0;
		pulse(0, 1'h0);
		chk(11'(cell_reg_q), 11'h0f5);
		@(posedge clk_sys);
		want <= 28'h0000033;
		pulse(0, 1'h0);
		chk(11'(cell_reg_q), 11'h0c6);
		@(posedge clk_sys);
		want <= {8'h0, 10'h0cc, 10'h0f0};
		set_cells(REG_JK, DSRC_DATA);
		pulse(0, 1'h0);
		chk(11'(cell_reg_q), 11'h032);
		@(posedge clk_sys);
		want <= {8'h0, 10'h035, 10'h02c};
		set_cells(REG_SR, DSRC_DATA);
		pulse(0, 1'h0);
		chk(11'(cell_reg_q), 11'h02a);
		@(posedge clk_sys);
		ctrl_line[5] <= 1'h1;
		want <= 28'h0000155;
		pulse(0, 1'h0);
		chk(11'(cell_reg_q), 11'h155);
		@(posedge clk_sys);
		ctrl_line[5] <= 1'h0;
		pack_fb_en <= '1;
		lut_mask <= {10{16'h0f0f}};
		set_cells(REG_D, DSRC_LUT);
		pulse(0, 1'h0);
		chk(11'(cell_reg_q), 11'h2aa);
		@(posedge clk_sys);
		pack_fb_en <= '0;
		set_cells(REG_D, DSRC_DATA);
		for (int i = 0; i < 10; i++) begin
			in_sel[i][2] <= 6'((i + 9) % 10);
		end
		pulse(0, 1'h0);
		chk(11'(cell_reg_q), 11'h155);
		$display("mode test done");
		finish_test();
	end
endmodule
